// File: core/tick_select.v
// Clock source selection and prescaler producing the timer tick enable
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.vh"

module tick_select (
  input wire clk,
  input wire rst,
  input wire [2:0] clock_select,
  input wire ext_count_pin,
  output reg timer_tick
);

  reg [`PRE_W-1:0] pre_r;
  reg ext_prev_r;
  wire ext_rise;
  wire ext_fall;

  assign ext_rise = ext_count_pin & ~ext_prev_r;
  assign ext_fall = ~ext_count_pin & ext_prev_r;

  // Free-running prescaler
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_r <= `PRE_RESET;
      ext_prev_r <= 1'b0;
    end else begin
      pre_r <= pre_r + `PRE_ONE;
      ext_prev_r <= ext_count_pin;
    end
  end

  always @* begin
    case (clock_select)
      `CS_STOP: timer_tick = 1'b0;
      `CS_DIV1: timer_tick = 1'b1;
      `CS_DIV8: timer_tick = ((pre_r & `PRE_MASK8) == `PRE_MASK8);
      `CS_DIV64: timer_tick = ((pre_r & `PRE_MASK64) == `PRE_MASK64);
      `CS_DIV256: timer_tick = ((pre_r & `PRE_MASK256) == `PRE_MASK256);
      `CS_DIV1024: timer_tick = (pre_r == `PRE_MASK1024);
      `CS_EXT_FALL: timer_tick = ext_fall;
      `CS_EXT_RISE: timer_tick = ext_rise;
      default: timer_tick = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

// File: core/timer8_core.v
// Eight-bit timer counter with two compare units and PWM buffering
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.vh"

// Function
// - Counter and both compare values are 8-bit registers.
// - All interrupt requests in one flag register, each gated by mask bit.
// - Tick from prescaled clock or external pin; stopped when select is zero.
// - Three-bit clock select in control B picks source and edge.
// - Each tick clears, increments or decrements counter per waveform mode.
// - CPU reads/writes counter anytime; write beats clear or count.
// - Bottom 0x00, max 0xFF, top is max or compare A by mode.
// - Three-bit waveform mode: two low bits in control A, high in B.
// - Overflow flag set at mode-defined point; may raise interrupt.
// - Continuous compare; match sets compare flag on following tick.
// - Compare flag clears on service or by writing one.
// - Match, top and bottom drive waveform generation per modes.
// - PWM modes double buffer compare values, update at top.
// - CPU compare writes go to buffer when buffering, else direct.
// - Force strobe in non-PWM updates output only, no flag, no counter.
// - Counter write blocks compare match on next tick, even stopped.
// - Compare output states persist across waveform mode changes.
// - Compare output mode bits unbuffered, effective immediately.
// - Mode zero counts up, wraps, sets overflow when becoming zero.
// - Mode two clears counter on compare A match; A is top.
// - Fast PWM bottom to top restart; top 0xFF mode 3, A mode 7.
// - Reset clears compare output state registers.
module timer8_core (
  input wire clk,
  input wire rst,
  input wire ext_count_pin,
  input wire counter_wr,
  input wire [`CNT_W-1:0] counter_wr_data,
  input wire compare_a_wr,
  input wire [`CNT_W-1:0] compare_a_wr_data,
  input wire compare_b_wr,
  input wire [`CNT_W-1:0] compare_b_wr_data,
  input wire control_a_wr,
  input wire [7:0] control_a_wr_data,
  input wire control_b_wr,
  input wire [7:0] control_b_wr_data,
  input wire flag_wr,
  input wire [`FLAG_W-1:0] flag_wr_data,
  input wire mask_wr,
  input wire [`FLAG_W-1:0] mask_wr_data,
  input wire [`FLAG_W-1:0] irq_ack,
  output wire [`CNT_W-1:0] counter_value,
  output wire [`CNT_W-1:0] compare_a_value,
  output wire [`CNT_W-1:0] compare_b_value,
  output wire [7:0] control_a_reg,
  output wire [7:0] control_b_reg,
  output wire [`FLAG_W-1:0] timer_flag_reg,
  output wire [`FLAG_W-1:0] timer_mask_reg,
  output wire [`FLAG_W-1:0] irq_req,
  output wire timer_tick,
  output wire match_a,
  output wire match_b,
  output wire top_hit,
  output wire bottom_hit,
  output wire wave_out_a,
  output wire wave_out_b
);

  reg [`CNT_W-1:0] cnt_r;
  reg [`CNT_W-1:0] cnt_nxt;
  reg [`CNT_W-1:0] cmp_a_r;
  reg [`CNT_W-1:0] cmp_b_r;
  reg [`CNT_W-1:0] buf_a_r;
  reg [`CNT_W-1:0] buf_b_r;
  reg [7:0] ctrl_a_r;
  reg [7:0] ctrl_b_r;
  reg [`FLAG_W-1:0] flag_r;
  reg [`FLAG_W-1:0] mask_r;
  reg down_r;
  reg down_nxt;
  reg block_r;
  reg wave_a_r;
  reg wave_b_r;
  reg ovf_set;

  wire [2:0] waveform_mode;
  wire [2:0] clock_select;
  wire [1:0] com_a;
  wire [1:0] com_b;
  wire pwm_mode;
  wire fast_mode;
  wire pc_mode;
  wire [`CNT_W-1:0] top_value;
  wire cmp_a_event;
  wire cmp_b_event;
  wire force_a;
  wire force_b;
  wire [`FLAG_W-1:0] flag_set;

  assign waveform_mode = {ctrl_b_r[`CTRLB_WGM2], ctrl_a_r[`CTRLA_WGM1], ctrl_a_r[`CTRLA_WGM0]};
  assign clock_select = ctrl_b_r[`CTRLB_CS_HI:`CTRLB_CS_LO];
  assign com_a = ctrl_a_r[`CTRLA_COMA_HI:`CTRLA_COMA_LO];
  assign com_b = ctrl_a_r[`CTRLA_COMB_HI:`CTRLA_COMB_LO];

  assign fast_mode = (waveform_mode == `WGM_FAST_MAX) || (waveform_mode == `WGM_FAST_CMPA);
  assign pc_mode = (waveform_mode == `WGM_PC_MAX) || (waveform_mode == `WGM_PC_CMPA);
  assign pwm_mode = fast_mode | pc_mode;

  assign top_value = ((waveform_mode == `WGM_CTC) || (waveform_mode == `WGM_FAST_CMPA) ||
                      (waveform_mode == `WGM_PC_CMPA)) ? cmp_a_r : `CNT_MAX;

  assign match_a = (cnt_r == cmp_a_r);
  assign match_b = (cnt_r == cmp_b_r);
  assign top_hit = (cnt_r == top_value);
  assign bottom_hit = (cnt_r == `CNT_BOTTOM);

  assign cmp_a_event = timer_tick & match_a & ~block_r;
  assign cmp_b_event = timer_tick & match_b & ~block_r;

  assign force_a = control_b_wr & control_b_wr_data[`CTRLB_FOCA] & ~pwm_mode;
  assign force_b = control_b_wr & control_b_wr_data[`CTRLB_FOCB] & ~pwm_mode;

  tick_select tick_select_inst (
    .clk(clk),
    .rst(rst),
    .clock_select(clock_select),
    .ext_count_pin(ext_count_pin),
    .timer_tick(timer_tick)
  );

  // Counter next value and overflow point
  always @* begin
    cnt_nxt = cnt_r;
    down_nxt = down_r;
    ovf_set = 1'b0;
    if (timer_tick) begin
      if (pc_mode) begin
        if (!down_r && top_hit) begin
          down_nxt = 1'b1;
          cnt_nxt = cnt_r - `CNT_ONE;
        end else if (down_r && bottom_hit) begin
          ovf_set = 1'b1;
          down_nxt = 1'b0;
          cnt_nxt = cnt_r + `CNT_ONE;
        end else if (down_r) begin
          cnt_nxt = cnt_r - `CNT_ONE;
        end else begin
          cnt_nxt = cnt_r + `CNT_ONE;
        end
      end else if (fast_mode) begin
        down_nxt = 1'b0;
        if (top_hit) begin
          cnt_nxt = `CNT_BOTTOM;
          ovf_set = 1'b1;
        end else begin
          cnt_nxt = cnt_r + `CNT_ONE;
        end
      end else if (waveform_mode == `WGM_CTC) begin
        down_nxt = 1'b0;
        if (top_hit) begin
          cnt_nxt = `CNT_BOTTOM;
        end else begin
          cnt_nxt = cnt_r + `CNT_ONE;
        end
        ovf_set = (cnt_r == `CNT_MAX);
      end else begin
        down_nxt = 1'b0;
        cnt_nxt = cnt_r + `CNT_ONE;
        ovf_set = (cnt_r == `CNT_MAX);
      end
    end
    if (counter_wr) begin
      cnt_nxt = counter_wr_data;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= `CNT_BOTTOM;
      down_r <= 1'b0;
      block_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      down_r <= down_nxt;
      if (counter_wr) begin
        block_r <= 1'b1;
      end else if (timer_tick) begin
        block_r <= 1'b0;
      end
    end
  end

  // Compare values and buffers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cmp_a_r <= `CNT_BOTTOM;
      cmp_b_r <= `CNT_BOTTOM;
      buf_a_r <= `CNT_BOTTOM;
      buf_b_r <= `CNT_BOTTOM;
    end else begin
      if (compare_a_wr) begin
        buf_a_r <= compare_a_wr_data;
      end
      if (compare_b_wr) begin
        buf_b_r <= compare_b_wr_data;
      end
      if (!pwm_mode) begin
        if (compare_a_wr) begin
          cmp_a_r <= compare_a_wr_data;
        end
        if (compare_b_wr) begin
          cmp_b_r <= compare_b_wr_data;
        end
      end else if (timer_tick && top_hit && !(pc_mode && down_r)) begin
        cmp_a_r <= buf_a_r;
        cmp_b_r <= buf_b_r;
      end
    end
  end

  // Control, flag and mask registers
  assign flag_set = {cmp_b_event, cmp_a_event, ovf_set};

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_a_r <= `CTRL_RESET;
      ctrl_b_r <= `CTRL_RESET;
      flag_r <= `FLAG_RESET;
      mask_r <= `FLAG_RESET;
    end else begin
      if (control_a_wr) begin
        ctrl_a_r <= control_a_wr_data;
      end
      if (control_b_wr) begin
        ctrl_b_r <= {2'b00, control_b_wr_data[5:0]};
      end
      if (mask_wr) begin
        mask_r <= mask_wr_data;
      end
      // clear by one or service, set wins
      flag_r <= (flag_r & ~((flag_wr ? flag_wr_data : `FLAG_RESET) | irq_ack)) | flag_set;
    end
  end

  assign irq_req = flag_r & mask_r;

  // Waveform output update for one channel
  function wave_next;
    input cur;
    input [1:0] com;
    input fast;
    input pc;
    input down;
    input hit;
    input at_bottom;
    begin
      wave_next = cur;
      if (fast) begin
        if (hit && com == `COM_CLEAR) begin
          wave_next = 1'b0;
        end else if (hit && com == `COM_SET) begin
          wave_next = 1'b1;
        end else if (at_bottom && com == `COM_CLEAR) begin
          wave_next = 1'b1;
        end else if (at_bottom && com == `COM_SET) begin
          wave_next = 1'b0;
        end
      end else if (pc) begin
        if (hit && com == `COM_CLEAR) begin
          wave_next = down;
        end else if (hit && com == `COM_SET) begin
          wave_next = ~down;
        end
      end else if (hit) begin
        case (com)
          `COM_TOGGLE: wave_next = ~cur;
          `COM_CLEAR: wave_next = 1'b0;
          `COM_SET: wave_next = 1'b1;
          default: wave_next = cur;
        endcase
      end
    end
  endfunction

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wave_a_r <= 1'b0;
      wave_b_r <= 1'b0;
    end else begin
      wave_a_r <= wave_next(wave_a_r, com_a, fast_mode, pc_mode, down_r,
                            cmp_a_event | force_a, timer_tick & fast_mode & top_hit);
      wave_b_r <= wave_next(wave_b_r, com_b, fast_mode, pc_mode, down_r,
                            cmp_b_event | force_b, timer_tick & fast_mode & top_hit);
    end
  end

  assign counter_value = cnt_r;
  assign compare_a_value = pwm_mode ? buf_a_r : cmp_a_r;
  assign compare_b_value = pwm_mode ? buf_b_r : cmp_b_r;
  assign control_a_reg = ctrl_a_r;
  assign control_b_reg = ctrl_b_r;
  assign timer_flag_reg = flag_r;
  assign timer_mask_reg = mask_r;
  assign wave_out_a = wave_a_r;
  assign wave_out_b = wave_b_r;

endmodule

`default_nettype wire

// File: core/timer_consts.vh
// Constants for the eight-bit timer compare core
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

`define CNT_W 8
`define CNT_BOTTOM 8'h00
`define CNT_MAX 8'hFF
`define CNT_ONE 8'h01

`define CTRL_RESET 8'h00
`define CTRLA_COMA_HI 7
`define CTRLA_COMA_LO 6
`define CTRLA_COMB_HI 5
`define CTRLA_COMB_LO 4
`define CTRLA_WGM1 1
`define CTRLA_WGM0 0
`define CTRLB_FOCA 7
`define CTRLB_FOCB 6
`define CTRLB_WGM2 3
`define CTRLB_CS_HI 2
`define CTRLB_CS_LO 0

`define FLAG_W 3
`define FLAG_OVF 0
`define FLAG_CMPA 1
`define FLAG_CMPB 2
`define FLAG_RESET 3'h0

`define WGM_NORMAL 3'h0
`define WGM_PC_MAX 3'h1
`define WGM_CTC 3'h2
`define WGM_FAST_MAX 3'h3
`define WGM_PC_CMPA 3'h5
`define WGM_FAST_CMPA 3'h7

`define COM_OFF 2'h0
`define COM_TOGGLE 2'h1
`define COM_CLEAR 2'h2
`define COM_SET 2'h3

`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7

`define PRE_W 10
`define PRE_MASK8 10'h007
`define PRE_MASK64 10'h03F
`define PRE_MASK256 10'h0FF
`define PRE_MASK1024 10'h3FF
`define PRE_ONE 10'h001
`define PRE_RESET 10'h000

`endif

// File: dv/timer8_core_monitor.sv
// Assertion checker for the eight-bit timer core
`timescale 1ns/1ps
`default_nettype none
module timer8_core_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic counter_wr,
  input wire logic [7:0] counter_wr_data,
  input wire logic [7:0] control_a_reg,
  input wire logic [7:0] control_b_reg,
  input wire logic [2:0] irq_ack,
  input wire logic [7:0] counter_value,
  input wire logic [2:0] timer_flag_reg,
  input wire logic [2:0] timer_mask_reg,
  input wire logic [2:0] irq_req,
  input wire logic timer_tick,
  input wire logic match_a
);
  wire [2:0] wm = {control_b_reg[3], control_a_reg[1:0]};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_write_loads_cnt: assert property (counter_wr |=> counter_value == $past(counter_wr_data))
    else $error("counter write not loaded");
  a_stop_no_tick: assert property (control_b_reg[2:0] == 3'h0 |-> !timer_tick)
    else $error("tick while stopped");
  a_div1_tick: assert property (control_b_reg[2:0] == 3'h1 |-> timer_tick)
    else $error("no tick at full rate");
  a_irq_gating: assert property (irq_req == (timer_flag_reg & timer_mask_reg))
    else $error("request not flag and mask");
  a_hold_no_tick: assert property (!timer_tick && !counter_wr |=> $stable(counter_value))
    else $error("counter moved without tick");
  a_count_up: assert property (wm == 3'h0 && timer_tick && !counter_wr
    |=> counter_value == $past(counter_value) + 8'h01)
    else $error("normal mode did not count up");
  a_normal_wrap: assert property (wm == 3'h0 && timer_tick && !counter_wr
    && counter_value == 8'hFF |=> counter_value == 8'h00 && timer_flag_reg[0])
    else $error("wrap without overflow flag");
  a_ctc_clear: assert property (wm == 3'h2 && timer_tick && match_a && !counter_wr
    && $past(timer_tick) && !$past(counter_wr) |=> counter_value == 8'h00)
    else $error("clear on compare missing");
  a_match_flag: assert property (wm == 3'h0 && timer_tick && match_a && !counter_wr
    && $past(timer_tick) && !$past(counter_wr) |=> timer_flag_reg[1])
    else $error("match did not set flag");
  a_write_blocks: assert property (counter_wr ##1 (!timer_tick && !counter_wr)[*2]
    ##1 (timer_tick && match_a && !counter_wr && !timer_flag_reg[1]) |=> !timer_flag_reg[1])
    else $error("match after counter write");
  a_ack_clears: assert property (wm == 3'h0 && irq_ack[0] && counter_value != 8'hFF
    |=> !timer_flag_reg[0])
    else $error("acknowledge left overflow flag");
endmodule
bind timer8_core timer8_core_monitor timer8_core_monitor_inst (.clk(clk), .rst(rst),
  .counter_wr(counter_wr), .counter_wr_data(counter_wr_data), .control_a_reg(control_a_reg),
  .control_b_reg(control_b_reg), .irq_ack(irq_ack), .counter_value(counter_value),
  .timer_flag_reg(timer_flag_reg), .timer_mask_reg(timer_mask_reg), .irq_req(irq_req),
  .timer_tick(timer_tick), .match_a(match_a));
`default_nettype wire

// File: dv/timer8_core_tb_top.sv
// Self-checking bench for the eight-bit timer core
`timescale 1ns/1ps
`default_nettype none
module timer8_core_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ext = 1'b0;
  logic [6:0] w = 7'h00;
  logic [7:0] d = 8'h00;
  logic [2:0] ack = 3'h0;
  logic [7:0] cnt, cav, cbr, cbv, car;
  logic [2:0] flg, irq, msk;
  logic ma, woa, th, bh, mb, wob;
  logic [15:0] seed = 16'hBC98;
  int fails = 0;
  int comparisons = 0;
  typedef struct {int s; logic [7:0] e;} note_t;
  note_t q[$];
  string nm [0:12] = '{"counter", "ovf", "cmpa", "wave_a", "irq", "cmp_a", "match_a", "ctrl_b",
    "cmp_b", "top_bottom", "match_b_wave_b", "mask", "ctrl_a"};
  timer8_core timer8_core_inst (.clk(clk), .rst(rst), .ext_count_pin(ext),
    .counter_wr(w[0]), .counter_wr_data(d), .compare_a_wr(w[1]), .compare_a_wr_data(d),
    .compare_b_wr(w[2]), .compare_b_wr_data(d), .control_a_wr(w[3]), .control_a_wr_data(d),
    .control_b_wr(w[4]), .control_b_wr_data(d), .flag_wr(w[5]), .flag_wr_data(d[2:0]),
    .mask_wr(w[6]), .mask_wr_data(d[2:0]), .irq_ack(ack), .counter_value(cnt),
    .compare_a_value(cav), .compare_b_value(cbv), .control_a_reg(car), .control_b_reg(cbr),
    .timer_flag_reg(flg), .timer_mask_reg(msk), .irq_req(irq), .timer_tick(), .match_a(ma),
    .match_b(mb), .top_hit(th), .bottom_hit(bh), .wave_out_a(woa), .wave_out_b(wob));
  initial begin
    forever #12.5 clk = ~clk;
  end
  function automatic logic [15:0] xs(logic [15:0] s);
    s = s ^ (s << 7);
    s = s ^ (s >> 9);
    return s ^ (s << 8);
  endfunction
  task automatic wr(int i, logic [7:0] v);
    @(posedge clk);
    w[i] <= 1'b1;
    d <= v;
    @(posedge clk);
    w[i] <= 1'b0;
  endtask
  task automatic ex(int s, logic [7:0] e);
    q.push_back('{s, e});
  endtask
  task automatic chk_reset;
    for (int i = 0; i < 13; i++) begin
      ex(i, (i == 6 || i == 9) ? 8'h01 : (i == 10) ? 8'h02 : 8'h00);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Scoreboard side
  always @(negedge clk) begin
    note_t n;
    logic [7:0] v;
    while (q.size() > 0) begin
      n = q.pop_front();
      case (n.s)
        0: v = cnt;
        1: v = {7'h00, flg[0]};
        2: v = {7'h00, flg[1]};
        3: v = {7'h00, woa};
        4: v = {7'h00, irq[0]};
        5: v = cav;
        6: v = {7'h00, ma};
        7: v = cbr;
        8: v = cbv;
        9: v = {6'h00, th, bh};
        10: v = {6'h00, mb, wob};
        11: v = {5'h00, msk};
        default: v = car;
      endcase
      comparisons++;
      if (v !== n.e) begin
        fails++;
        $display("MISMATCH %s expected %h seen %h", nm[n.s], n.e, v);
      end
    end
  end
  initial begin
    cyc(5000);
    fails++;
    tally_and_finish;
  end
  initial begin
    logic [7:0] r, b;
    cyc(3);
    rst <= 1'b0;
    chk_reset;
    seed = xs(seed);
    r = {1'b0, seed[6:0]};
    b = seed[15:8];
    wr(2, b);
    ex(8, b);
    wr(0, r);
    cyc(4);
    ex(0, r);
    ex(10, {6'h00, (r == b), 1'b0});
    wr(4, 8'h01);
    wr(0, 8'hFD);
    cyc(3);
    ex(0, 8'h00);
    ex(1, 8'h01);
    wr(6, 8'h01);
    ex(4, 8'h01);
    ex(11, 8'h01);
    @(posedge clk);
    ack <= 3'h1;
    @(posedge clk);
    ack <= 3'h0;
    ex(1, 8'h00);
    wr(5, 8'h02);
    ex(2, 8'h00);
    wr(1, 8'h40);
    wr(0, 8'h3E);
    cyc(4);
    ex(2, 8'h01);
    wr(5, 8'h02);
    wr(4, 8'h00);
    wr(0, 8'h40);
    wr(4, 8'h01);
    cyc(4);
    ex(2, 8'h00);
    wr(1, 8'h05);
    wr(3, 8'h02);
    ex(12, 8'h02);
    wr(0, 8'h00);
    cyc(5);
    ex(9, 8'h02);
    cyc(1);
    ex(0, 8'h00);
    wr(4, 8'h00);
    wr(5, 8'h07);
    wr(3, 8'h70);
    wr(0, 8'h77);
    wr(4, 8'hC0);
    ex(3, 8'h01);
    ex(10, {6'h00, (b == 8'h77), 1'b1});
    ex(2, 8'h00);
    ex(0, 8'h77);
    wr(3, 8'h80);
    wr(4, 8'h80);
    ex(3, 8'h00);
    wr(3, 8'h40);
    wr(4, 8'h80);
    wr(3, 8'h43);
    wr(4, 8'h80);
    ex(3, 8'h01);
    wr(1, 8'h22);
    ex(5, 8'h22);
    wr(0, 8'h22);
    ex(6, 8'h00);
    wr(0, 8'hFE);
    wr(4, 8'h01);
    cyc(1);
    ex(9, 8'h02);
    cyc(1);
    ex(1, 8'h01);
    cyc(34);
    ex(6, 8'h01);
    for (int c = 7; c > 5; c--) begin
      wr(4, 8'h00);
      wr(0, 8'h10);
      wr(4, c[7:0]);
      repeat (3) begin
        @(posedge clk);
        ext <= 1'b1;
        cyc(2);
        ext <= 1'b0;
        cyc(2);
      end
      cyc(2);
      ex(0, 8'h13);
    end
    wr(4, 8'h00);
    wr(0, 8'h00);
    wr(4, 8'h02);
    cyc(16);
    ex(0, 8'h02);
    wr(4, 8'h00);
    wr(3, 8'h01);
    wr(0, 8'hFE);
    wr(4, 8'h01);
    cyc(3);
    ex(0, 8'hFD);
    cyc(1);
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    chk_reset;
    cyc(2);
    tally_and_finish;
  end
endmodule
`default_nettype wire
